// ---- design/tslr_map.svh ----
// constants of the tdm slot routing and loopback block
// assumes a tdm line with up to 64 eight-bit slots and a frame sync
//
// Overview of operation
// - slot zero is found from the sampled frame sync, or when the slot count wraps after the last slot
// - channel loopback mode loops every virtual channel inside the serial channel
// - channel loopback sends channels in the order of the transmit routing table
// - channel loopback returns transmit data to the same channel, bypassing routing
// - interface loopback returns transmit slot n as receive slot n, receive-routed
// - bit 15 of a routing entry loops back only that one line slot
// - shared routing maps up to 64 slots onto 64 distinct channels
// - split mode maps one line onto the 32 channels of one serial channel
// - transparent channels align from slot timing only, no pattern search
`ifndef TSLR_MAP_SVH
`define TSLR_MAP_SVH

`define TSLR_SLOTS_WIDE 64
`define TSLR_LAST_WIDE 6'h3f
`define TSLR_LAST_SPLIT 6'h1f
`define TSLR_ENT_LOOP 15
`define TSLR_ENT_VALID 14
`define TSLR_ENT_PTR_HI 11
`define TSLR_ENT_PTR_LO 6
`define TSLR_ENTRY_RST 16'h0000
`define TSLR_IDLE_BYTE 8'hff
`define TSLR_LAST_BIT 3'h7
`define TSLR_FIFO_WIDTH 14
`define TSLR_FIFO_DEPTH 8

`endif

// ---- design/tslr_pkg.sv ----
// types of the tdm slot routing and loopback block
// assumes tslr_map.svh is on the include path
`include "tslr_map.svh"

package tslr_pkg;

   typedef logic [15:0] tslr_entry_t;
   typedef logic [5:0] tslr_chan_t;
   typedef logic [`TSLR_FIFO_WIDTH-1:0] tslr_word_t;

endpackage : tslr_pkg

// ---- design/tslr_fifo_if.sv ----
// valid/ready carrier between the slot engine and its receive fifo
// assumes both ends run on clk_sys
interface tslr_fifo_if;
   import tslr_pkg::*;

   logic in_valid;
   logic in_ready;
   tslr_word_t in_data;
   logic out_valid;
   logic out_ready;
   tslr_word_t out_data;

   modport fifo (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
   modport src (output in_valid, output in_data, input in_ready);
   modport snk (input out_valid, input out_data, output out_ready);
endinterface : tslr_fifo_if

// ---- design/tslr_fifo.sv ----
// flip-flop fifo with valid and ready on both sides
// assumes a single clock and an asynchronous active-high reset
module tslr_fifo
   import tslr_pkg::*;
#(
   parameter int WIDTH = `TSLR_FIFO_WIDTH,
   parameter int DEPTH = `TSLR_FIFO_DEPTH
) (
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // async reset, active high
   tslr_fifo_if.fifo port_f // push and pop sides
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } tslr_fifo_st_t;

   tslr_fifo_st_t q, d;
   logic push, pop;

   assign port_f.in_ready = (q.cnt != DEPTH[AW:0]);
   assign port_f.out_valid = (q.cnt != '0);
   assign port_f.out_data = q.mem[q.rd];
   assign push = port_f.in_valid & port_f.in_ready;
   assign pop = port_f.out_valid & port_f.out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = port_f.in_data;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : tslr_fifo

// ---- design/tslr_core.sv ----
// tdm slot routing and loopback engine with receive fifo
// assumes the line clock, sync and receive data are asynchronous pins
// sampled on clk_sys; the line clock must be well below half of clk_sys
module tslr_core
   import tslr_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // async reset, active high
   input wire logic tdm_clk, // line bit clock from framer
   input wire logic tdm_sync, // frame sync, high in bit 0 of slot 0
   input wire logic tdm_rxd, // line receive data
   output logic tdm_txd, // line transmit data
   input wire logic channel_general_mode_loop, // channel level loopback
   input wire logic serial_iface_mode_loop, // interface wide loopback
   input wire logic wide_map, // shared 64 slot routing
   input wire logic serial_channel_id, // which serial channel in split mode
   input wire logic tab_wr, // routing table write strobe
   input wire logic tab_tx, // 1 writes transmit half, 0 receive half
   input wire logic [5:0] tab_slot, // slot index of the write
   input wire tslr_entry_t tab_entry, // entry value to write
   output logic tx_req, // pulse: supply tx_data for tx_chan
   output tslr_chan_t tx_chan, // channel for the next transmit slot
   input wire logic [7:0] tx_data, // transmit byte of tx_chan
   output logic rx_valid, // receive word available
   output tslr_chan_t rx_chan, // channel of the receive byte
   output logic [7:0] rx_data, // receive byte
   input wire logic rx_ready, // consumer takes the word
   output logic overrun, // sticky: a byte was dropped
   input wire logic overrun_clr, // clears overrun
   output logic frame_lock // a frame sync has been seen
);

   typedef struct packed {
      logic [`TSLR_SLOTS_WIDE-1:0][15:0] tx_tab;
      logic [`TSLR_SLOTS_WIDE-1:0][15:0] rx_tab;
      logic clk_s1;
      logic clk_s2;
      logic clk_p;
      logic sync_s1;
      logic sync_s2;
      logic rxd_s1;
      logic rxd_s2;
      logic [2:0] bit_cnt;
      logic [5:0] slot;
      logic synced;
      logic [7:0] rx_sh;
      logic [7:0] tx_sh;
      logic txd;
      logic tx_act;
      logic tx_req;
      tslr_chan_t tx_chan;
      logic push_valid;
      tslr_word_t push_data;
      logic overrun;
      logic out_valid;
      tslr_word_t out_data;
   } tslr_state_t;

   tslr_state_t q, d;
   tslr_fifo_if fifo_c ();

   // channel number named by a routing entry
   function automatic tslr_chan_t ent_chan(input tslr_entry_t e, input logic wide,
                                           input logic sc_id);
      tslr_chan_t c;
      c = e[`TSLR_ENT_PTR_HI:`TSLR_ENT_PTR_LO];
      if (!wide) begin
         c = {sc_id, c[4:0]};
      end
      return c;
   endfunction : ent_chan

   // an entry takes part only if valid and inside the frame
   function automatic logic ent_live(input tslr_entry_t e, input logic [5:0] s,
                                     input logic wide);
      return e[`TSLR_ENT_VALID] & (wide | (s <= `TSLR_LAST_SPLIT));
   endfunction : ent_live

   tslr_fifo #(
      .WIDTH(`TSLR_FIFO_WIDTH),
      .DEPTH(`TSLR_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .port_f(fifo_c.fifo)
   );

   assign fifo_c.in_valid = q.push_valid;
   assign fifo_c.in_data = q.push_data;
   // output stage holds a word in flops so the ports come from registers
   assign fifo_c.out_ready = ~q.out_valid | rx_ready;

   assign tdm_txd = q.txd;
   assign tx_req = q.tx_req;
   assign tx_chan = q.tx_chan;
   assign rx_valid = q.out_valid;
   assign rx_chan = q.out_data[13:8];
   assign rx_data = q.out_data[7:0];
   assign overrun = q.overrun;
   assign frame_lock = q.synced;

   always_comb begin
      logic rise;
      logic fall;
      logic [2:0] cur_bit;
      logic [5:0] cur_slot;
      logic [5:0] nxt_slot;
      logic [5:0] last;
      tslr_entry_t rx_ent;
      tslr_entry_t tx_ent;
      logic rx_bit;
      logic [7:0] byte_out;

      d = q;
      rise = 1'b0;
      fall = 1'b0;
      cur_bit = q.bit_cnt;
      cur_slot = q.slot;
      nxt_slot = '0;
      last = wide_map ? `TSLR_LAST_WIDE : `TSLR_LAST_SPLIT;
      rx_ent = `TSLR_ENTRY_RST;
      tx_ent = `TSLR_ENTRY_RST;
      rx_bit = 1'b1;
      byte_out = `TSLR_IDLE_BYTE;

      // two flops on every pin before any logic looks at it
      d.clk_s1 = tdm_clk;
      d.clk_s2 = q.clk_s1;
      d.clk_p = q.clk_s2;
      d.sync_s1 = tdm_sync;
      d.sync_s2 = q.sync_s1;
      d.rxd_s1 = tdm_rxd;
      d.rxd_s2 = q.rxd_s1;
      rise = q.clk_s2 & ~q.clk_p;
      fall = ~q.clk_s2 & q.clk_p;

      d.push_valid = 1'b0;
      d.tx_req = 1'b0;

      if (tab_wr) begin
         if (tab_tx) begin
            d.tx_tab[tab_slot] = tab_entry;
         end else begin
            d.rx_tab[tab_slot] = tab_entry;
         end
      end

      // line sampled on the rising edge of the line clock
      if (rise) begin
         if (q.sync_s2) begin
            cur_bit = '0;
            cur_slot = '0;
            d.synced = 1'b1;
         end
         // shared routing reads both directions from the transmit half
         rx_ent = wide_map ? q.tx_tab[cur_slot] : q.rx_tab[cur_slot];
         if (serial_iface_mode_loop || rx_ent[`TSLR_ENT_LOOP]) begin
            rx_bit = q.txd;
         end else begin
            rx_bit = q.rxd_s2;
         end
         d.rx_sh = {q.rx_sh[6:0], rx_bit};
         if (cur_bit == `TSLR_LAST_BIT) begin
            // byte boundary comes from the bit count only
            if ((q.synced || q.sync_s2) && !channel_general_mode_loop
                && ent_live(rx_ent, cur_slot, wide_map)) begin
               d.push_valid = 1'b1;
               d.push_data = {ent_chan(rx_ent, wide_map, serial_channel_id),
                              d.rx_sh};
            end
            nxt_slot = (cur_slot == last) ? '0 : cur_slot + 6'h01;
            tx_ent = q.tx_tab[nxt_slot];
            d.slot = nxt_slot;
            d.bit_cnt = '0;
            d.tx_chan = ent_chan(tx_ent, wide_map, serial_channel_id);
            d.tx_act = ent_live(tx_ent, nxt_slot, wide_map);
            d.tx_req = 1'b1;
         end else begin
            d.slot = cur_slot;
            d.bit_cnt = cur_bit + 3'h1;
         end
      end

      // transmit bits change on the falling edge, msb first
      if (fall) begin
         if (q.bit_cnt == '0) begin
            if (q.tx_act && !channel_general_mode_loop) begin
               byte_out = tx_data;
            end
            d.txd = byte_out[7];
            d.tx_sh = {byte_out[6:0], 1'b1};
            // channel loopback: byte goes back to its own channel, no routing
            if (q.tx_act && channel_general_mode_loop && q.synced) begin
               d.push_valid = 1'b1;
               d.push_data = {q.tx_chan, tx_data};
            end
         end else begin
            d.txd = q.tx_sh[7];
            d.tx_sh = {q.tx_sh[6:0], 1'b1};
         end
      end

      // the line cannot wait, so a full fifo drops the byte and flags it
      if (overrun_clr) begin
         d.overrun = 1'b0;
      end
      if (q.push_valid && !fifo_c.in_ready) begin
         d.overrun = 1'b1;
      end

      if (fifo_c.out_ready) begin
         d.out_valid = fifo_c.out_valid;
         d.out_data = fifo_c.out_data;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
         q.txd <= 1'b1;
         q.tx_sh <= `TSLR_IDLE_BYTE;
         q.clk_p <= 1'b0;
      end else begin
         q <= d;
      end
   end

endmodule : tslr_core

// ---- sim/tslr_core_props.sv ----
// port assertions for the slot routing core
// assumes one clk_sys domain, bound to every tslr_core
module tslr_core_chk
   import tslr_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic sys_rst, // reset
   input wire logic tdm_txd, // line out
   input wire logic channel_general_mode_loop, // chan loop
   input wire logic wide_map, // shared map
   input wire logic serial_channel_id, // split msb
   input wire logic tx_req, // tx strobe
   input wire tslr_chan_t tx_chan, // tx chan
   input wire logic rx_valid, // rx valid
   input wire tslr_chan_t rx_chan, // rx chan
   input wire logic [7:0] rx_data, // rx byte
   input wire logic rx_ready, // rx taken
   input wire logic overrun, // drop flag
   input wire logic overrun_clr, // flag clear
   input wire logic frame_lock // sync seen
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // a byte already on the wire may finish, so allow two slots
   logic [6:0] loop_cnt_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         loop_cnt_q <= 7'h00;
      end else if (!channel_general_mode_loop) begin
         loop_cnt_q <= 7'h00;
      end else if (loop_cnt_q != 7'h7f) begin
         loop_cnt_q <= loop_cnt_q + 7'h01;
      end
   end
   sequence s_tx_quiet;
      !tx_req [*8];
   endsequence
   property p_reset_quiet;
      $fell(sys_rst) |-> tdm_txd && !rx_valid && !overrun && !frame_lock;
   endproperty
   property p_unlocked;
      !frame_lock |-> !rx_valid && tdm_txd;
   endproperty
   property p_lock_held;
      frame_lock |=> frame_lock;
   endproperty
   property p_tx_spacing;
      tx_req |=> s_tx_quiet;
   endproperty
   property p_rx_hold;
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_chan) && $stable(rx_data);
   endproperty
   property p_overrun_held;
      overrun && !overrun_clr |=> overrun;
   endproperty
   property p_split_msb;
      !wide_map |-> (!rx_valid || rx_chan[5] == serial_channel_id)
         && (!tx_req || tx_chan[5] == serial_channel_id);
   endproperty
   property p_chan_loop_idle;
      loop_cnt_q == 7'h7f |-> tdm_txd;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not idle after reset");
   a_unlocked: assert property (p_unlocked)
      else $error("traffic before frame sync");
   a_lock_held: assert property (p_lock_held)
      else $error("frame lock lost");
   a_tx_spacing: assert property (p_tx_spacing)
      else $error("tx_req twice in a slot");
   a_rx_hold: assert property (p_rx_hold)
      else $error("rx word changed before taken");
   a_overrun_held: assert property (p_overrun_held)
      else $error("overrun dropped without clear");
   a_split_msb: assert property (p_split_msb)
      else $error("split channel outside its serial channel");
   a_chan_loop_idle: assert property (p_chan_loop_idle)
      else $error("line not idle in channel loop");
endmodule : tslr_core_chk

bind tslr_core tslr_core_chk u_chk (.clk_sys, .sys_rst, .tdm_txd,
   .channel_general_mode_loop, .wide_map, .serial_channel_id, .tx_req, .tx_chan,
   .rx_valid, .rx_chan, .rx_data, .rx_ready, .overrun, .overrun_clr, .frame_lock);

// ---- sim/tslr_framer.sv ----
// line framer model: bit clock, frame sync, receive data
// assumes the core samples on the rising bit clock, msb first
module tslr_framer (
   output logic tdm_clk, // still between frames
   output logic tdm_sync, // frame sync
   output logic tdm_rxd, // line data
   input logic tdm_txd // line data from the core
);
   timeunit 1ns;
   timeprecision 1ns;
   // bytes seen on the core's transmit pin, one per slot
   logic [7:0] txb [64];
   initial begin
      tdm_clk = 1'b0;
      tdm_sync = 1'b0;
      tdm_rxd = 1'b1;
   end
   // one clock and sync serve both directions
   task automatic run(input int nslots);
      #37;
      for (int s = 0; s < nslots; s++) begin
         for (int i = 7; i >= 0; i--) begin
            tdm_sync = (s == 0 && i == 7);
            tdm_rxd = 1'((8'ha5 ^ 8'(s)) >> i);
            #400 tdm_clk = 1'b1;
            txb[s] = {txb[s][6:0], tdm_txd};
            #400 tdm_clk = 1'b0;
         end
      end
      tdm_sync = 1'b0;
      tdm_rxd = ~tdm_rxd; // no stale bit once released
   endtask : run
endmodule : tslr_framer

// ---- sim/tslr_core_test.sv ----
// self-checking bench of the slot routing core
// assumes design, checker and framer model compiled first
module tslr_core_test;
   timeunit 1ns;
   timeprecision 1ns;
   import tslr_pkg::*;
   logic clk_sys, sys_rst, tdm_clk, tdm_sync, tdm_rxd, tdm_txd, tab_wr, tab_tx;
   logic channel_general_mode_loop, serial_iface_mode_loop, wide_map, serial_channel_id;
   logic tx_req, rx_valid, rx_ready, overrun, overrun_clr, frame_lock;
   logic [5:0] tab_slot;
   logic [7:0] tx_data, rx_data;
   tslr_entry_t tab_entry;
   tslr_chan_t tx_chan, rx_chan;
   int error_cnt, samples_checked, cyc;
   logic [13:0] got[$], want[$];
   tslr_core dut (.clk_sys, .sys_rst, .tdm_clk, .tdm_sync, .tdm_rxd, .tdm_txd,
      .channel_general_mode_loop, .serial_iface_mode_loop, .wide_map, .serial_channel_id,
      .tab_wr, .tab_tx, .tab_slot, .tab_entry, .tx_req, .tx_chan, .tx_data, .rx_valid,
      .rx_chan, .rx_data, .rx_ready, .overrun, .overrun_clr, .frame_lock);
   tslr_framer u_frm (.tdm_clk, .tdm_sync, .tdm_rxd, .tdm_txd);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      tx_data <= #1 {2'h2, tx_chan};
      cyc <= cyc + 1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back({rx_chan, rx_data});
      if (cyc > 40000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [13:0] seen, want_v);
      samples_checked++;
      if (seen !== want_v) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, want_v, seen);
      end
   endtask : chk
   task automatic restart(input logic cl, il, wm, id);
      @(posedge clk_sys) #1 sys_rst = 1'b1;
      {channel_general_mode_loop, serial_iface_mode_loop, wide_map, serial_channel_id} =
         {cl, il, wm, id};
      got.delete();
      want.delete();
      repeat (2) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      @(posedge clk_sys) #1;
      chk("txd_idle", 14'(tdm_txd), 14'h1);
      chk("lock_idle", 14'(frame_lock), 14'h0);
   endtask : restart
   task automatic wr(input logic tx, input int slot, input logic lp, input logic [5:0] ptr);
      @(posedge clk_sys) #1;
      {tab_wr, tab_tx, tab_slot} = {1'b1, tx, 6'(slot)};
      tab_entry = {lp, 1'b1, 2'h0, ptr, 6'h00};
      @(posedge clk_sys) #1 tab_wr = 1'b0;
   endtask : wr
   task automatic frame_cmp(input string what, input int nslots);
      u_frm.run(nslots);
      repeat (60) @(posedge clk_sys);
      chk({what, "_lock"}, 14'(frame_lock), 14'h1);
      chk({what, "_n"}, 14'(got.size()), 14'(want.size()));
      foreach (want[i]) chk(what, got[i], want[i]);
   endtask : frame_cmp
   task automatic sc_route;
      restart(0, 0, 0, 1);
      wr(0, 0, 0, 6'h05);
      wr(0, 9, 0, 6'h13);
      wr(1, 4, 0, 6'h0b);
      want = '{{6'h25, 8'ha5}, {6'h33, 8'hac}};
      frame_cmp("route", 32);
      chk("line_tx", 14'(u_frm.txb[4]), 14'h00ab);
      chk("line_idle", 14'(u_frm.txb[5]), 14'h00ff);
   endtask : sc_route
   task automatic sc_slot_loop;
      restart(0, 0, 0, 0);
      wr(1, 2, 0, 6'h09);
      wr(0, 2, 1, 6'h09);
      wr(0, 4, 0, 6'h03);
      want = '{{6'h09, 8'h89}, {6'h03, 8'ha1}};
      frame_cmp("slot_loop", 32);
   endtask : sc_slot_loop
   task automatic sc_iface_loop;
      restart(0, 1, 0, 0);
      wr(1, 3, 0, 6'h01);
      wr(0, 3, 0, 6'h04);
      wr(1, 5, 0, 6'h06);
      wr(0, 5, 0, 6'h06);
      wr(0, 7, 0, 6'h02);
      want = '{{6'h04, 8'h81}, {6'h06, 8'h86}, {6'h02, 8'hff}};
      frame_cmp("iface_loop", 32);
   endtask : sc_iface_loop
   task automatic sc_chan_loop;
      restart(1, 0, 0, 0);
      wr(1, 6, 0, 6'h02);
      wr(1, 1, 0, 6'h1f);
      wr(0, 1, 0, 6'h07);
      want = '{{6'h1f, 8'h9f}, {6'h02, 8'h82}};
      frame_cmp("chan_loop", 32);
      chk("chan_loop_line", 14'(u_frm.txb[1]), 14'h00ff);
   endtask : sc_chan_loop
   task automatic sc_wide;
      restart(0, 0, 1, 0);
      wr(1, 40, 0, 6'h28);
      wr(1, 63, 0, 6'h3e);
      want = '{{6'h28, 8'h8d}, {6'h3e, 8'h9a}};
      frame_cmp("wide", 64);
   endtask : sc_wide
   task automatic sc_overrun;
      restart(0, 0, 0, 0);
      rx_ready = 1'b0;
      for (int s = 0; s < 12; s++) begin
         wr(0, s, 0, 6'(s));
         want.push_back({6'(s), 8'(8'ha5 ^ s)});
      end
      u_frm.run(32);
      chk("overrun", 14'(overrun), 14'h1);
      @(posedge clk_sys) #1 rx_ready = 1'b1;
      repeat (20) @(posedge clk_sys);
      chk("fifo_n", 14'(got.size()), 14'h9);
      for (int i = 0; i < 8; i++) chk("fifo", got[i], want[i]);
      #1 overrun_clr = 1'b1;
      @(posedge clk_sys) #1 overrun_clr = 1'b0;
      chk("overrun_clr", 14'(overrun), 14'h0);
   endtask : sc_overrun
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      {sys_rst, rx_ready, tab_wr, tab_tx, overrun_clr} = 5'h18;
      {channel_general_mode_loop, serial_iface_mode_loop, wide_map, serial_channel_id} = 4'h0;
      {tab_slot, tab_entry} = 22'h0;
      repeat (2) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      sc_route();
      sc_slot_loop();
      sc_iface_loop();
      sc_chan_loop();
      sc_wide();
      sc_overrun();
      finish_test();
   end
endmodule : tslr_core_test
